// ===== include/msa_pkg.sv
// Package: register map, flag positions and carrier types of the alert mask
//
// What this block does
// R01: Mask register at code 2, bits 14:0, resets zero
// R02: Bit 0 alerts on measurement-active rise
// R03: Bit 2 alerts on capacitance/ESR pending rise
// R04: Bit 3 alerts on capacitance done rise
// R05: Bit 4 alerts on ESR done rise
// R06: Bit 5 alerts on measurement failed rise
// R07: Bit 7 alerts on charger disabled rise
// R08: Bit 8 alerts on capacitance measurement running rise
// R09: Bit 9 alerts on ESR measurement running rise
// R10: Bit 10 alerts on input power failed rise
// R11: Previous flags kept; only unmasked rises alert
package msa_pkg;

  // ==========================================================
  // Register map
  localparam int MSA_CMD_W = 8;
  localparam int MSA_FLAG_W = 15;
  localparam logic [MSA_CMD_W-1:0] MSA_CMD_MASK = 8'h02;
  localparam logic [MSA_FLAG_W-1:0] MSA_MASK_RESET = 15'h0000;

  // ==========================================================
  // Flag positions
  localparam int MSA_B_MEAS_ACTIVE = 0;
  localparam int MSA_B_CAPESR_PENDING = 2;
  localparam int MSA_B_CAP_DONE = 3;
  localparam int MSA_B_ESR_DONE = 4;
  localparam int MSA_B_MEAS_FAILED = 5;
  localparam int MSA_B_CHARGER_OFF = 7;
  localparam int MSA_B_CAP_RUNNING = 8;
  localparam int MSA_B_ESR_RUNNING = 9;
  localparam int MSA_B_POWER_FAILED = 10;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic [MSA_CMD_W-1:0] cmd;
    logic [MSA_FLAG_W-1:0] wdata;
  } msa_req_s;

  typedef logic [MSA_FLAG_W-1:0] msa_flags_t;

endpackage

// ===== verilog/msa_edge_detect.sv
// Per-flag rising edge detector gated by the enable mask
`timescale 1ns/100ps
module msa_edge_detect
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire msa_pkg::msa_flags_t flags,
  input wire msa_pkg::msa_flags_t enable,
  output logic hit
);
  import msa_pkg::*;

  msa_flags_t prev;
  msa_flags_t rise;

  // ==========================================================
  // Previous values and gated rises
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prev <= MSA_MASK_RESET;
    else if (ce)
      prev <= flags; // R11
  end

  genvar i;
  generate
    for (i = 0; i < MSA_FLAG_W; i++)
    begin : g_bit
      assign rise[i] = flags[i] & ~prev[i] & enable[i]; // R11
    end
  endgenerate

  assign hit = |rise;

endmodule // msa_edge_detect

// ===== verilog/msa_alert_mask.sv
// Monitor status alert mask: register, edge detection, alert output
`timescale 1ns/100ps
module msa_alert_mask
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire msa_pkg::msa_req_s req,
  input wire logic [msa_pkg::MSA_CMD_W-1:0] rd_cmd,
  input wire msa_pkg::msa_flags_t mon_flags,
  input wire logic alert_clear,
  output msa_pkg::msa_flags_t rd_data,
  output logic alert_n
);
  import msa_pkg::*;

  msa_flags_t enable;
  msa_flags_t flags_s1;
  msa_flags_t flags_s2;
  logic hit;

  // ==========================================================
  // Mask register
  // Writes to any other code are dropped, not stored
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      enable <= MSA_MASK_RESET; // R01
    else if (ce && req.wr && req.cmd == MSA_CMD_MASK)
      enable <= req.wdata; // R01
  end

  // Unmapped codes read zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= MSA_MASK_RESET;
    else if (ce)
      rd_data <= (rd_cmd == MSA_CMD_MASK) ? enable : MSA_MASK_RESET;
  end

  // ==========================================================
  // Flags may come from other analog domains, so synchronise
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_s1 <= MSA_MASK_RESET;
      flags_s2 <= MSA_MASK_RESET;
    end
    else if (ce)
    begin
      flags_s1 <= mon_flags;
      flags_s2 <= flags_s1;
    end
  end

  msa_edge_detect u_edge
  (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .flags(flags_s2),
    .enable(enable),
    .hit(hit)
  );

  // ==========================================================
  // Alert latch; a new edge wins over the host clear
  // A falling flag never releases it; only the host clear or reset does
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      alert_n <= 1'b1;
    else if (ce)
    begin
      if (hit)
        alert_n <= 1'b0; // R02 R03 R04 R05 R06 R07 R08 R09 R10
      else if (alert_clear)
        alert_n <= 1'b1;
    end
  end

  // ==========================================================
  // Checks; single clock domain, reset cancels every attempt
  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rst_n);

  // ==========================================================
  // Named steps of the alert behaviour
  // Steps use the synchronised flags, not the pins
  // Live cycle with the synchronised flag still low
  sequence s_flag_low(int b);
    ce && !flags_s2[b];
  endsequence

  // Next live cycle sees it high while its mask bit is set
  sequence s_flag_high_armed(int b);
    ce && enable[b] && flags_s2[b];
  endsequence

  // Live cycle with the alert down and no release asked for
  sequence s_alert_held;
    ce && !alert_n && !alert_clear;
  endsequence

  // Live cycle with a release request and no competing rise
  sequence s_clear_alone;
    ce && alert_clear && !hit;
  endsequence

  // Rise of one armed flag pulls the alert down one cycle later
  property p_alert_on_rise(int b);
    s_flag_low(b) ##1 s_flag_high_armed(b) |=> !alert_n;
  endproperty

  // ==========================================================
  // Register checks
  a_mask_reset: assert property ( // R01
    $rose(rst_n) |-> enable == MSA_MASK_RESET)
    else $error("mask not zero after reset");

  a_out_reset: assert property ( // R01
    $rose(rst_n) |-> rd_data == MSA_MASK_RESET && alert_n)
    else $error("outputs not idle after reset");

  a_mask_write: assert property ( // R01
    ce && req.wr && req.cmd == MSA_CMD_MASK
    |=> enable == $past(req.wdata))
    else $error("mask write lost");

  a_mask_hold: assert property ( // R01
    !(ce && req.wr && req.cmd == MSA_CMD_MASK) |=> $stable(enable))
    else $error("mask changed without a write");

  a_read_mask: assert property ( // R01
    ce && rd_cmd == MSA_CMD_MASK |=> rd_data == $past(enable))
    else $error("mask read wrong");

  a_read_other: assert property ( // R01
    ce && rd_cmd != MSA_CMD_MASK |=> rd_data == MSA_MASK_RESET)
    else $error("unmapped read not zero");

  // ==========================================================
  // One check per documented flag
  // Other bits alert too when unmasked, but carry no check here
  a_meas_active: assert property ( // R02
    p_alert_on_rise(MSA_B_MEAS_ACTIVE))
    else $error("no alert on measurement active");

  a_capesr_pend: assert property ( // R03
    p_alert_on_rise(MSA_B_CAPESR_PENDING))
    else $error("no alert on pending");

  a_cap_done: assert property ( // R04
    p_alert_on_rise(MSA_B_CAP_DONE))
    else $error("no alert on cap done");

  a_esr_done: assert property ( // R05
    p_alert_on_rise(MSA_B_ESR_DONE))
    else $error("no alert on esr done");

  a_meas_failed: assert property ( // R06
    p_alert_on_rise(MSA_B_MEAS_FAILED))
    else $error("no alert on failure");

  a_charger_off: assert property ( // R07
    p_alert_on_rise(MSA_B_CHARGER_OFF))
    else $error("no alert on charger off");

  a_cap_running: assert property ( // R08
    p_alert_on_rise(MSA_B_CAP_RUNNING))
    else $error("no alert on cap running");

  a_esr_running: assert property ( // R09
    p_alert_on_rise(MSA_B_ESR_RUNNING))
    else $error("no alert on esr running");

  a_power_fail: assert property ( // R10
    p_alert_on_rise(MSA_B_POWER_FAILED))
    else $error("no alert on power fail");

  // ==========================================================
  // Synchroniser, alert latch and edge history
  a_sync_chain: assert property (
    ce |=> flags_s1 == $past(mon_flags) && flags_s2 == $past(flags_s1))
    else $error("flag synchroniser skipped a stage");

  a_prev_track: assert property ( // R11
    ce |=> u_edge.prev == $past(flags_s2))
    else $error("flag history not kept");

  a_no_false_alert: assert property ( // R11
    ce && alert_n && !(|(flags_s2 & ~u_edge.prev & enable)) |=> alert_n)
    else $error("alert without unmasked rise");

  a_fall_cause: assert property ( // R11
    $fell(alert_n) |-> $past(hit))
    else $error("alert fell without a rise");

  a_rise_wins: assert property ( // R11
    ce && hit |=> !alert_n)
    else $error("rise lost to host clear");

  a_alert_stands: assert property (
    s_alert_held |=> !alert_n)
    else $error("alert released without a clear");

  a_clear_release: assert property (
    s_clear_alone |=> alert_n)
    else $error("alert not released by clear");

  a_rise_cause: assert property (
    $rose(alert_n) |-> $past(alert_clear))
    else $error("alert released with no clear seen");

  // A frozen cycle must leave mask, read data, alert and flag history as they were
  a_ce_freeze: assert property ( // R01 R11
    !ce |=> $stable(enable) && $stable(rd_data)
    && $stable(alert_n) && $stable(u_edge.prev))
    else $error("state moved while clock enable low");

endmodule // msa_alert_mask

// ===== verification/msa_host_model.sv
// Host model that services the alert line with a late clear
`timescale 1ns/100ps
module msa_host_model
#(
  parameter int WAIT = 2
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic alert_n,
  output logic alert_clear
);
  int cnt;
  // ==========================================================
  // Clear held until the alert lets go, a few cycles late
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      alert_clear <= 1'b0;
    end
    else
    begin
      cnt <= alert_n ? 0 : cnt + 1;
      alert_clear <= !alert_n && cnt >= WAIT;
    end
  end
endmodule // msa_host_model

// ===== verification/msa_alert_mask_bench.sv
// Self-checking bench for the monitor status alert mask
`timescale 1ns/100ps
`define CHK(a, e, m) \
  begin \
    cmp_count++; \
    if ((a) !== (e)) \
    begin \
      err_count++; \
      $display("[FAIL] %0t ns: %s", $time, m); \
    end \
  end
module msa_alert_mask_bench;
  import msa_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  msa_req_s req = '0;
  logic [MSA_CMD_W-1:0] rd_cmd = '0;
  msa_flags_t mon_flags = '0;
  msa_flags_t rd_data;
  logic alert_clear;
  logic alert_n;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int bits [9] = '{0, 2, 3, 4, 5, 7, 8, 9, 10};
  always #2 clk = ~clk;
  msa_alert_mask uut (.clk(clk), .rst_n(rst_n), .ce(ce), .req(req),
    .rd_cmd(rd_cmd), .mon_flags(mon_flags), .alert_clear(alert_clear),
    .rd_data(rd_data), .alert_n(alert_n));
  msa_host_model #(.WAIT(2)) host (.clk(clk), .rst_n(rst_n),
    .alert_n(alert_n), .alert_clear(alert_clear));
  // ==========================================================
  // Bus tasks
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [MSA_CMD_W-1:0] c, input msa_flags_t d);
    req = '{1'b1, c, d};
    cyc(1);
    req.wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [MSA_CMD_W-1:0] c, output msa_flags_t d);
    rd_cmd = c;
    cyc(2);
    d = rd_data;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    msa_flags_t d;
    rd(MSA_CMD_MASK, d);
    `CHK(d, MSA_MASK_RESET, "mask reset")
    wr(MSA_CMD_MASK, 15'h7FFF);
    wr(8'h03, 15'h0000);
    rd(MSA_CMD_MASK, d);
    `CHK(d, 15'h7FFF, "mask readback")
    rd(8'h01, d);
    `CHK(d, 15'h0000, "unmapped read")
  endtask
  task automatic t_bit(input int b);
    wr(MSA_CMD_MASK, 15'h0001 << b);
    mon_flags[b] = 1'b1;
    cyc(2);
    `CHK(alert_n, 1'b1, "alert early")
    cyc(1);
    `CHK(alert_n, 1'b0, "no alert")
    for (int i = 0; i < 10 && alert_n !== 1'b1; i++) cyc(1);
    `CHK(alert_n, 1'b1, "alert not cleared")
    mon_flags[b] = 1'b0;
    cyc(4);
  endtask
  task automatic t_quiet;
    wr(MSA_CMD_MASK, 15'h0000);
    mon_flags = 15'h7FFF;
    cyc(6);
    `CHK(alert_n, 1'b1, "masked rise")
    wr(MSA_CMD_MASK, 15'h7FFF);
    cyc(6);
    `CHK(alert_n, 1'b1, "held flag")
    mon_flags = 15'h0000;
    cyc(4);
  endtask
  // Second rise lands on the edge the host clear arrives
  task automatic t_race;
    wr(MSA_CMD_MASK, (15'h0001 << MSA_B_MEAS_ACTIVE)
      | (15'h0001 << MSA_B_ESR_DONE));
    mon_flags[MSA_B_MEAS_ACTIVE] = 1'b1;
    cyc(4);
    mon_flags[MSA_B_ESR_DONE] = 1'b1;
    cyc(2);
    `CHK(alert_n, 1'b0, "first rise lost")
    cyc(1);
    `CHK(alert_n, 1'b0, "rise lost to clear")
    for (int i = 0; i < 10 && alert_n !== 1'b1; i++) cyc(1);
    `CHK(alert_n, 1'b1, "alert not cleared")
    mon_flags = 15'h0000;
    cyc(4);
  endtask
  task automatic t_freeze;
    msa_flags_t d;
    wr(MSA_CMD_MASK, 15'h0001 << MSA_B_CAP_DONE);
    ce = 1'b0;
    wr(MSA_CMD_MASK, 15'h7FFF);
    mon_flags[MSA_B_CAP_DONE] = 1'b1;
    cyc(6);
    `CHK(alert_n, 1'b1, "alert while frozen")
    ce = 1'b1;
    rd(MSA_CMD_MASK, d);
    `CHK(d, 15'h0001 << MSA_B_CAP_DONE, "write landed while frozen")
    `CHK(alert_n, 1'b1, "alert before sync delay")
    cyc(1);
    `CHK(alert_n, 1'b0, "no alert after freeze")
    for (int i = 0; i < 10 && alert_n !== 1'b1; i++) cyc(1);
    `CHK(alert_n, 1'b1, "alert not cleared")
    mon_flags[MSA_B_CAP_DONE] = 1'b0;
    cyc(4);
  endtask
  task automatic t_reset;
    msa_flags_t d;
    wr(MSA_CMD_MASK, 15'h7FFF);
    rst_n = 1'b0;
    cyc(2);
    `CHK(rd_data, MSA_MASK_RESET, "read data kept in reset")
    `CHK(alert_n, 1'b1, "alert in reset")
    rst_n = 1'b1;
    rd(MSA_CMD_MASK, d);
    `CHK(d, MSA_MASK_RESET, "mask kept over reset")
  endtask
  task automatic end_of_test;
    $display("Compares %0d, errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================
  // Run far beyond the few hundred cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      end_of_test;
    end
  end
  initial
  begin
    cyc(6);
    rst_n = 1'b1;
    t_regs;
    foreach (bits[i]) t_bit(bits[i]);
    t_race;
    t_freeze;
    t_quiet;
    t_reset;
    end_of_test;
  end
endmodule // msa_alert_mask_bench
